// ### rx_ptp_sop_timestamp_pkg.sv
package rx_ptp_sop_timestamp_pkg;

  localparam int          time_width      = 80;
  localparam int          lane_count      = 20;
  localparam int          lane_idx_width  = 5;
  localparam int          fill_width      = 7;
  localparam int          seg_count       = 4;

  // normal clock mode field widths
  localparam int          sec_width       = 48;
  localparam int          ns_width        = 32;
  // transparent clock mode field positions
  localparam int          tc_sign_bit     = 63;
  localparam int          tc_ns_msb       = 62;
  localparam int          tc_ns_lsb       = 16;
  localparam int          tc_frac_msb     = 15;
  localparam int          tc_frac_lsb     = 0;

  localparam logic [79:0] time_reset      = 80'h0;
  localparam logic [4:0]  lane_reset      = 5'h0;
  localparam logic [6:0]  fill_reset      = 7'h0;

  typedef struct packed {
    logic [47:0] seconds;
    logic [31:0] nanoseconds;
  } normal_time_type;

  typedef struct packed {
    logic [15:0] unused;
    logic        sign;
    logic [46:0] nanoseconds;
    logic [15:0] frac_ns;
  } transparent_time_type;

  typedef struct packed {
    logic [79:0] capture_time;
    logic [4:0]  lane_index;
  } sop_report_type;

  localparam sop_report_type report_reset = '{time_reset, lane_reset};

endpackage

// ### rx_ptp_sop_timestamp.sv
module rx_ptp_sop_timestamp #(
  parameter int lanes    = rx_ptp_sop_timestamp_pkg::lane_count,
  parameter int segments = rx_ptp_sop_timestamp_pkg::seg_count
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [79:0]  rx_system_time_in,
  input  wire logic         transparent_mode,
  input  wire logic [lanes-1:0] sop_plane_hit,
  input  wire logic [segments-1:0] bus_sop,
  input  wire logic [lanes-1:0][6:0] deskew_fill_in,
  output logic      [79:0]  rx_sop_capture_time,
  output logic      [4:0]   rx_sop_lane_index,
  output logic      [lanes-1:0][6:0] rx_lane_deskew_fill_level,
  output logic              report_ready
);

  // the logic is written for these exact sizes, with any segment count from one up; refuse anything else
  initial begin
    if (lanes != rx_ptp_sop_timestamp_pkg::lane_count) begin
      $error("lane count must match the 5-bit index and 20 lanes");
    end
    if (segments < 1) begin
      $error("at least one bus segment is needed");
    end
    if (rx_ptp_sop_timestamp_pkg::time_width != 80) begin
      $error("timer word must be 80 bits wide");
    end
    if (rx_ptp_sop_timestamp_pkg::lane_idx_width != 5) begin
      $error("lane index must be 5 bits wide");
    end
    if (rx_ptp_sop_timestamp_pkg::fill_width != 7) begin
      $error("fill level must be 7 bits wide");
    end
    if (rx_ptp_sop_timestamp_pkg::lane_count
        > 2 ** rx_ptp_sop_timestamp_pkg::lane_idx_width) begin
      $error("lane index too narrow for the lane count");
    end
    if (rx_ptp_sop_timestamp_pkg::sec_width
        + rx_ptp_sop_timestamp_pkg::ns_width
        != rx_ptp_sop_timestamp_pkg::time_width) begin
      $error("seconds and nanoseconds must fill the timer word");
    end
    if ($bits(rx_ptp_sop_timestamp_pkg::normal_time_type)
        != rx_ptp_sop_timestamp_pkg::time_width) begin
      $error("normal view must cover the timer word");
    end
    if ($bits(rx_ptp_sop_timestamp_pkg::transparent_time_type)
        != rx_ptp_sop_timestamp_pkg::time_width) begin
      $error("transparent view must cover the timer word");
    end
    if (rx_ptp_sop_timestamp_pkg::tc_sign_bit
        != rx_ptp_sop_timestamp_pkg::tc_ns_msb + 1) begin
      $error("sign must sit just above the nanoseconds");
    end
    if (rx_ptp_sop_timestamp_pkg::tc_ns_lsb
        != rx_ptp_sop_timestamp_pkg::tc_frac_msb + 1) begin
      $error("nanoseconds must sit just above the fraction");
    end
    if (rx_ptp_sop_timestamp_pkg::tc_frac_lsb != 0) begin
      $error("fraction must start at bit 0");
    end
    if (rx_ptp_sop_timestamp_pkg::tc_sign_bit
        >= rx_ptp_sop_timestamp_pkg::time_width) begin
      $error("sign bit must lie inside the timer word");
    end
    if ($bits(rx_ptp_sop_timestamp_pkg::sop_report_type)
        != rx_ptp_sop_timestamp_pkg::time_width
        + rx_ptp_sop_timestamp_pkg::lane_idx_width) begin
      $error("report must hold one time and one lane index");
    end
  end

  // lowest lane wins when several lanes see the sop in one cycle
  function automatic logic [4:0] first_lane(input logic [lanes-1:0] hits);
    logic [4:0] idx;
    idx = rx_ptp_sop_timestamp_pkg::lane_reset;
    for (int i = lanes - 1; i >= 0; i--) begin
      if (hits[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // timer synchroniser: the timer word is on the lane serial clock
  logic [79:0] time_s1_q;
  logic [79:0] time_s2_q;
  logic [79:0] time_s3_q;
  logic [79:0] time_q;
  logic [79:0] time_d;
  logic [79:0] time_s1_d;
  logic [79:0] time_s2_d;
  logic [79:0] time_s3_d;

  // a word is taken only after two equal samples, so a sample caught
  // mid-change is never used; the cost is one cycle of extra latency
  always_comb begin
    time_s1_d = rx_system_time_in;
    time_s2_d = time_s1_q;
    time_s3_d = time_s2_q;
    time_d    = time_q;
    if (time_s2_q == time_s3_q) begin
      time_d = time_s2_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      time_s1_q <= rx_ptp_sop_timestamp_pkg::time_reset;
      time_s2_q <= rx_ptp_sop_timestamp_pkg::time_reset;
      time_s3_q <= rx_ptp_sop_timestamp_pkg::time_reset;
      time_q    <= rx_ptp_sop_timestamp_pkg::time_reset;
    end else begin
      time_s1_q <= time_s1_d;
      time_s2_q <= time_s2_d;
      time_s3_q <= time_s3_d;
      time_q    <= time_d;
    end
  end

  // the layout is not reshaped in either mode; the views only name fields
  rx_ptp_sop_timestamp_pkg::normal_time_type      normal_view;
  rx_ptp_sop_timestamp_pkg::transparent_time_type tc_view;
  rx_ptp_sop_timestamp_pkg::sop_report_type       stamp;

  always_comb begin
    normal_view = time_q;
    tc_view     = time_q;
    stamp.capture_time = transparent_mode ? 80'(tc_view)
                                          : 80'(normal_view);
    stamp.lane_index   = first_lane(sop_plane_hit);
  end

  // report stage plus one pending slot for a second packet in flight
  rx_ptp_sop_timestamp_pkg::sop_report_type out_q;
  rx_ptp_sop_timestamp_pkg::sop_report_type out_d;
  rx_ptp_sop_timestamp_pkg::sop_report_type pend_q;
  rx_ptp_sop_timestamp_pkg::sop_report_type pend_d;
  logic out_busy_q;
  logic out_busy_d;
  logic pend_valid_q;
  logic pend_valid_d;
  logic hit;
  logic consumed;

  always_comb begin
    hit          = |sop_plane_hit;
    consumed     = |bus_sop;
    out_d        = out_q;
    out_busy_d   = out_busy_q;
    pend_d       = pend_q;
    pend_valid_d = pend_valid_q;
    if (consumed) begin
      if (pend_valid_q) begin
        out_d        = pend_q;
        pend_valid_d = 1'b0;
      end else begin
        out_busy_d = 1'b0;
      end
    end
    if (hit) begin
      if (!out_busy_d) begin
        out_d      = stamp;
        out_busy_d = 1'b1;
      end else begin
        // a third packet before the first leaves overwrites the slot
        pend_d       = stamp;
        pend_valid_d = 1'b1;
      end
    end
  end

  logic [lanes-1:0][6:0] fill_q;
  logic [lanes-1:0][6:0] fill_d;

  // fill levels already run on this clock, so one register is enough
  always_comb begin
    fill_d = deskew_fill_in;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_q <= '{default: rx_ptp_sop_timestamp_pkg::fill_reset};
    end else begin
      fill_q <= fill_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q        <= rx_ptp_sop_timestamp_pkg::report_reset;
      pend_q       <= rx_ptp_sop_timestamp_pkg::report_reset;
      out_busy_q   <= 1'b0;
      pend_valid_q <= 1'b0;
    end else begin
      out_q        <= out_d;
      pend_q       <= pend_d;
      out_busy_q   <= out_busy_d;
      pend_valid_q <= pend_valid_d;
    end
  end

  always_comb begin
    rx_sop_capture_time       = out_q.capture_time;
    rx_sop_lane_index         = out_q.lane_index;
    rx_lane_deskew_fill_level = fill_q;
    report_ready              = out_busy_q;
  end

endmodule

// ### rx_ptp_sop_timestamp_assertions.sv
module rx_ptp_sop_timestamp_chk #(
  parameter int lanes    = 20,
  parameter int segments = 4
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [79:0]            rx_system_time_in,
  input wire logic                   transparent_mode,
  input wire logic [lanes-1:0]       sop_plane_hit,
  input wire logic [segments-1:0]    bus_sop,
  input wire logic [lanes-1:0][6:0]  deskew_fill_in,
  input wire logic [79:0]            rx_sop_capture_time,
  input wire logic [4:0]             rx_sop_lane_index,
  input wire logic [lanes-1:0][6:0]  rx_lane_deskew_fill_level,
  input wire logic                   report_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // only a capture into a free report stage shows at once
  wire hit = |sop_plane_hit & !report_ready;
  // timer must have settled through the crossing before it is trusted
  sequence s_st; $stable(rx_system_time_in)[*8] ##0 hit; endsequence
  property p_nrm; s_st ##0 !transparent_mode |=>
    rx_sop_capture_time[79:32] == $past(rx_system_time_in[79:32]);
  endproperty
  a_nrm: assert property (p_nrm) else $error("seconds wrong");
  property p_tc; s_st ##0 transparent_mode |=>
    rx_sop_capture_time[63] == $past(rx_system_time_in[63]);
  endproperty
  a_tc: assert property (p_tc) else $error("sign wrong");
  property p_time; s_st |=>
    rx_sop_capture_time == $past(rx_system_time_in);
  endproperty
  a_time: assert property (p_time) else $error("time wrong");
  property p_rdy; hit |=> report_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("no report");
  property p_hold; report_ready && !bus_sop |=>
    report_ready && $stable(rx_sop_capture_time);
  endproperty
  a_hold: assert property (p_hold) else $error("report lost");
  property p_idx; hit && sop_plane_hit[0] |=> rx_sop_lane_index == 5'h0;
  endproperty
  a_idx: assert property (p_idx) else $error("lane wrong");
  property p_fill; !$past(rst) |->
    rx_lane_deskew_fill_level == $past(deskew_fill_in);
  endproperty
  a_fill: assert property (p_fill) else $error("fill wrong");
endmodule
bind rx_ptp_sop_timestamp rx_ptp_sop_timestamp_chk
  #(.lanes(lanes), .segments(segments)) chk_i (.*);

// ### rx_ptp_app_model.sv
module rx_ptp_app_model (
  input  wire logic        clk,
  input  wire logic [79:0] time_set,
  input  wire logic        take,
  output logic      [79:0] time_out,
  output logic      [3:0]  sop_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial time_out = 80'h0;
  // lane 0 serial clock is the only clock in this bench
  always @(posedge clk) time_out <= #1 time_set;
  // segment choice follows the timer so every segment gets used
  assign sop_out = take ? 4'h1 << time_set[1:0] : 4'h0;
endmodule

// ### rx_ptp_sop_timestamp_tb.sv
module rx_ptp_sop_timestamp_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk = 0, rst = 1, mode = 0, take = 0, rdy;
  logic [79:0]      tset = 0, tin, cap;
  logic [19:0]      hit = 0, h1, h2;
  logic [19:0][6:0] fin = 0, fout;
  logic [4:0]       idx;
  logic [3:0]       sop;
  int               errors = 0, total_checks = 0;
  always #50 clk = ~clk;
  rx_ptp_app_model app (.clk, .time_set(tset), .take, .time_out(tin),
    .sop_out(sop));
  rx_ptp_sop_timestamp dut (.clk, .rst, .rx_system_time_in(tin),
    .transparent_mode(mode), .sop_plane_hit(hit), .bus_sop(sop),
    .deskew_fill_in(fin), .rx_sop_capture_time(cap),
    .rx_sop_lane_index(idx), .rx_lane_deskew_fill_level(fout),
    .report_ready(rdy));
  task automatic chk(string n, logic [139:0] s, e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [4:0] low(logic [19:0] h);
    for (int i = 19; i >= 0; i--)
      if (h[i]) low = 5'(i);
  endfunction
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(73905));
    step(5);
    rst = 0;
    chk("ready", rdy, 0);
    for (int k = 0; k < 12; k++) begin
      tset = 80'({$urandom, $urandom, $urandom});
      mode = k[0];
      foreach (fin[i]) fin[i] = 7'($urandom);
      step(10);
      chk("fill", fout, fin);
      h1 = k ? 20'($urandom) | 20'h400 : 20'h80000;
      hit = h1;
      step();
      // second hit lands while the first report is still unread
      h2 = k[1] ? 20'h1 : 20'($urandom) | 20'h8;
      hit = h2;
      step();
      hit = 0;
      chk("time", cap, tset);
      chk("lane", idx, low(h1));
      chk("ready", rdy, 1);
      take = 1;
      step();
      take = 0;
      step();
      chk("lane", idx, low(h2));
      take = 1;
      step();
      take = 0;
      step();
      chk("ready", rdy, 0);
    end
    conclude;
  end
endmodule
